// file: hdl/dacc_consts.vh
// constants for the dual array capture/compare block
// assumes inclusion by bare name from the design file
`ifndef DACC_CONSTS_VH
`define DACC_CONSTS_VH

`define DACC_CH_N        32
`define DACC_TMR_N       4
`define DACC_TW          16
`define DACC_PIN_MASK    32'h0fffffff
`define DACC_TMR_MAX     16'hffff
`define DACC_PRESC_DIV   16'h0008

// register map: 5-bit regions of paddr_i[11:7], then 12-bit byte addresses
`define DACC_REG_VAL     5'h00
`define DACC_REG_CTL     5'h01
`define DACC_REG_MISC    5'h02
`define DACC_OFF_TMR     12'h100
`define DACC_OFF_RLD     12'h110
`define DACC_OFF_TCTL    12'h120
`define DACC_OFF_GCTL    12'h124
`define DACC_OFF_IST     12'h128
`define DACC_OFF_IMSK    12'h12c

// channel control fields
`define DACC_CTL_TSEL    0
`define DACC_CTL_FN      3:1
`define DACC_CTL_EDGE    5:4
`define DACC_CTL_SINGLE  6
`define DACC_CTL_DOUBLE  7
`define DACC_FN_OFF      3'h0
`define DACC_FN_CAP      3'h1
`define DACC_FN_CM0      3'h2
`define DACC_FN_CM1      3'h3
`define DACC_FN_CM2      3'h4
`define DACC_FN_CM3      3'h5

// timer control fields, eight bits per timer, then the global control stagger bit
`define DACC_TC_RUN      0
`define DACC_TC_SEL      3:1
`define DACC_CS_GP       3'h6
`define DACC_CS_EXT      3'h7
`define DACC_GC_STAGGER  0

`endif

// file: hdl/dacc_top.v
// dual array capture/compare block: four timers, 32 channels, apb registers
// assumes synchronous pins, gp overflow pulse and ext counts in mclk_i domain
// Notes on behaviour
// RQ1: 32 channels; one-cycle event resolution, eight cycles when staggered
// RQ2: four 16-bit timers with reload, two per channel array
// RQ3: timer clock from prescaled system clock or gp module two overflow
// RQ4: first timer of each array may count an external input
// RQ5: sixteen channels per array, each picks timer and capture or compare
// RQ6: second array has pins on twelve channels only
// RQ7: compare mode 0 interrupts on every match
// RQ8: compare mode 1 toggles pin on every match
// RQ9: compare mode 2 interrupts at most once per timer period
// RQ10: compare mode 3 sets pin on match, clears on timer overflow
// RQ11: double register mode toggles one shared pin on either match
// RQ12: single event option stops a channel after one event
// RQ13: capture copies timer into channel register and raises interrupt
// RQ14: capture edge is rising, falling or both
// RQ15: compare channels are checked against their timer in the cycle after each count
// RQ16: timer reloads from its reload register on overflow
`timescale 1ns/1ps
`include "dacc_consts.vh"

module dacc_top #(
    parameter TW = `DACC_TW
) (
    input  wire             mclk_i,
    input  wire             sys_rst_i,
    input  wire             psel_i,
    input  wire             penable_i,
    input  wire             pwrite_i,
    input  wire [11:0]      paddr_i,
    input  wire [31:0]      pwdata_i,
    output reg  [31:0]      prdata_o,
    output reg              pready_o,
    output reg              pslverr_o,
    input  wire [31:0]      cc_in_i,
    output wire [31:0]      cc_out_o,
    output wire [31:0]      cc_oe_o,
    input  wire [1:0]       ext_cnt_i,
    input  wire             gp_ovf_i,
    output reg              irq_o
);

    localparam [31:0] PINS = `DACC_PIN_MASK;

    // count-clock select decode, shared by all four timers
    function tick_sel;
        input [2:0]  sel;
        input [15:0] presc;
        input        gp;
        input        ext;
        input        first;
        reg   [15:0] pmask;
        begin
            pmask = (`DACC_PRESC_DIV << sel) - 16'h0001;
            if (sel == `DACC_CS_GP)
                tick_sel = gp;
            else if (sel == `DACC_CS_EXT)
                tick_sel = first & ext;
            else
                tick_sel = ((presc & pmask) == pmask);
        end
    endfunction

    reg  [15:0]     presc;
    reg  [2:0]      slot;
    reg  [1:0]      ext_prev;
    reg  [31:0]     tctl;
    reg  [31:0]     gctl;
    reg  [31:0]     ist;
    reg  [31:0]     imsk;
    reg  [3:0]      t_chg;
    reg  [3:0]      t_ovf;
    wire [63:0]     tv_all;
    wire [63:0]     rl_all;
    wire [511:0]    ccv_all;
    wire [255:0]    ctl_all;
    wire [31:0]     fire_v;
    wire [1:0]      ext_rise;
    wire            acc;
    wire            wr_en;
    wire [4:0]      region;
    wire [4:0]      ch_idx;

    assign ext_rise = ext_cnt_i & ~ext_prev;
    assign acc      = psel_i & penable_i;
    assign wr_en    = acc & pready_o & pwrite_i;
    assign region   = paddr_i[11:7];
    assign ch_idx   = paddr_i[6:2];

    // free prescaler, stagger slot and external edge detect
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            presc    <= 16'h0000;
            slot     <= 3'h0;
            ext_prev <= 2'h0;
        end else begin
            presc    <= presc + 16'h0001;
            slot     <= slot + 3'h1; // [RQ1]
            ext_prev <= ext_cnt_i;
        end
    end

    // four timers
    genvar t;
    generate
        for (t = 0; t < `DACC_TMR_N; t = t + 1) begin : g_tmr
            reg  [TW-1:0] tv;
            reg  [TW-1:0] rl;
            wire [7:0]    tc;
            wire          tick;
            assign tc   = tctl[t*8 +: 8];
            assign tick = tc[`DACC_TC_RUN] &
                          tick_sel(tc[`DACC_TC_SEL], presc, gp_ovf_i,
                                   ext_rise[t/2], (t % 2) == 0); // [RQ3] [RQ4]
            assign tv_all[t*16 +: 16] = tv;
            assign rl_all[t*16 +: 16] = rl;
            always @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    tv <= {TW{1'b0}};
                    rl <= {TW{1'b0}};
                    t_chg[t] <= 1'b0;
                    t_ovf[t] <= 1'b0;
                end else begin
                    t_chg[t] <= tick;
                    t_ovf[t] <= tick & (tv == `DACC_TMR_MAX);
                    if (wr_en && paddr_i == `DACC_OFF_RLD + t*4)
                        rl <= pwdata_i[TW-1:0];
                    if (wr_en && paddr_i == `DACC_OFF_TMR + t*4)
                        tv <= pwdata_i[TW-1:0];
                    else if (tick && tv == `DACC_TMR_MAX)
                        tv <= rl; // [RQ16]
                    else if (tick)
                        tv <= tv + 16'h0001; // [RQ2]
                end
            end
        end
    endgenerate

    // 32 channels, two arrays of sixteen
    genvar c;
    generate
        for (c = 0; c < `DACC_CH_N; c = c + 1) begin : g_ch
            reg  [7:0]    ctl;
            reg  [TW-1:0] ccv;
            reg           pin;
            reg           oe;
            reg           done;
            reg           spent;
            reg           pend;
            reg           prev;
            wire [1:0]    ti;
            wire [TW-1:0] tval;
            wire [2:0]    fn;
            wire          is_cmp;
            wire          eq_hit;
            wire          cap_hit;
            wire          raw;
            wire          slot_ok;
            wire          act;
            wire          fire;
            wire          once;
            wire          ovf_hit;
            wire          mate;
            wire          dbl;
            wire          wr_ctl;
            wire          wr_val;
            assign ti      = {c >= 16, ctl[`DACC_CTL_TSEL]}; // [RQ5]
            assign tval    = tv_all[ti*16 +: 16];
            assign fn      = ctl[`DACC_CTL_FN];
            assign ovf_hit = t_ovf[ti];
            assign is_cmp  = (fn >= `DACC_FN_CM0) && (fn <= `DACC_FN_CM3);
            assign eq_hit  = is_cmp & t_chg[ti] & (ccv == tval); // [RQ15]
            assign cap_hit = (fn == `DACC_FN_CAP) & PINS[c] &
                             ((ctl[4] & cc_in_i[c] & ~prev) |
                              (ctl[5] & ~cc_in_i[c] & prev)); // [RQ6] [RQ14]
            assign raw     = eq_hit | cap_hit | pend;
            assign slot_ok = ~gctl[`DACC_GC_STAGGER] | (slot == c % 8); // [RQ1]
            assign act     = raw & slot_ok & ~spent; // [RQ12]
            assign once    = (fn == `DACC_FN_CM2) | (fn == `DACC_FN_CM3);
            assign fire    = act & ~(once & done); // [RQ7] [RQ9]
            assign fire_v[c] = fire;
            assign dbl     = ctl[`DACC_CTL_DOUBLE] & ((c % 16) < 8);
            if ((c % 16) < 8) begin : g_mate
                assign mate = fire_v[c+8];
            end else begin : g_nomate
                assign mate = 1'b0;
            end
            assign wr_ctl  = wr_en && region == `DACC_REG_CTL && ch_idx == c;
            assign wr_val  = wr_en && region == `DACC_REG_VAL && ch_idx == c;
            assign ccv_all[c*16 +: 16] = ccv;
            assign ctl_all[c*8 +: 8]   = ctl;
            assign cc_out_o[c] = pin;
            assign cc_oe_o[c]  = oe;
            always @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    ctl   <= 8'h00;
                    ccv   <= {TW{1'b0}};
                    pin   <= 1'b0;
                    oe    <= 1'b0;
                    done  <= 1'b0;
                    spent <= 1'b0;
                    pend  <= 1'b0;
                    prev  <= 1'b0;
                end else begin
                    prev <= cc_in_i[c];
                    pend <= raw & ~slot_ok & ~spent;
                    done <= fire | (done & ~ovf_hit); // [RQ9] [RQ10]
                    if (wr_ctl) begin
                        ctl   <= pwdata_i[7:0];
                        spent <= 1'b0;
                    end else if (fire && ctl[`DACC_CTL_SINGLE]) begin
                        spent <= 1'b1; // [RQ12]
                    end
                    if (fire && fn == `DACC_FN_CAP)
                        ccv <= tval; // [RQ13]
                    else if (wr_val)
                        ccv <= pwdata_i[TW-1:0];
                    oe <= PINS[c] & ((fn == `DACC_FN_CM1) |
                                     (fn == `DACC_FN_CM3) | dbl);
                    if (dbl && (fire || mate))
                        pin <= ~pin; // [RQ11]
                    else if (fire && fn == `DACC_FN_CM1)
                        pin <= ~pin; // [RQ8]
                    else if (fire && fn == `DACC_FN_CM3)
                        pin <= 1'b1; // [RQ10]
                    else if (ovf_hit && fn == `DACC_FN_CM3)
                        pin <= 1'b0; // [RQ10]
                end
            end
        end
    endgenerate

    // global regs and sticky interrupt status
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tctl  <= 32'h00000000;
            gctl  <= 32'h00000000;
            imsk  <= 32'h00000000;
            ist   <= 32'h00000000;
            irq_o <= 1'b0;
        end else begin
            if (wr_en && paddr_i == `DACC_OFF_TCTL)
                tctl <= pwdata_i;
            if (wr_en && paddr_i == `DACC_OFF_GCTL)
                gctl <= pwdata_i & 32'h00000001;
            if (wr_en && paddr_i == `DACC_OFF_IMSK)
                imsk <= pwdata_i;
            if (wr_en && paddr_i == `DACC_OFF_IST)
                ist <= (ist & ~pwdata_i) | fire_v; // [RQ7] [RQ13]
            else
                ist <= ist | fire_v;
            irq_o <= |(ist & imsk);
        end
    end

    // apb read decode
    reg [31:0] rd_data;
    reg        rd_ok;
    always @* begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b1;
        if (region == `DACC_REG_VAL)
            rd_data = {16'h0000, ccv_all[ch_idx*16 +: 16]};
        else if (region == `DACC_REG_CTL)
            rd_data = {24'h000000, ctl_all[ch_idx*8 +: 8]};
        else if (paddr_i[11:4] == `DACC_OFF_TMR >> 4)
            rd_data = {16'h0000, tv_all[paddr_i[3:2]*16 +: 16]};
        else if (paddr_i[11:4] == `DACC_OFF_RLD >> 4)
            rd_data = {16'h0000, rl_all[paddr_i[3:2]*16 +: 16]};
        else if (paddr_i == `DACC_OFF_TCTL)
            rd_data = tctl;
        else if (paddr_i == `DACC_OFF_GCTL)
            rd_data = gctl;
        else if (paddr_i == `DACC_OFF_IST)
            rd_data = ist;
        else if (paddr_i == `DACC_OFF_IMSK)
            rd_data = imsk;
        else
            rd_ok = 1'b0;
    end

    // one wait state: ready one cycle into the access phase
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else begin
            pready_o  <= acc & ~pready_o;
            pslverr_o <= acc & ~pready_o & ~rd_ok;
            if (acc && !pready_o && !pwrite_i)
                prdata_o <= rd_data;
        end
    end

endmodule

// file: tb/dacc_checker.sv
// port assertions for the dual array capture/compare block
// assumes binding onto dacc_top, one clock domain
`timescale 1ns/1ps
module dacc_checker (
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [31:0] cc_out_o,
    input wire logic [31:0] cc_oe_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    property p_rdy_pulse; pready_o |=> !pready_o; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
    property p_rdy_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("ready not in second access");
    property p_rdy_cause; pready_o |-> psel_i && penable_i; endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("ready outside access");
    property p_idle; !psel_i |=> !pready_o; endproperty
    a_idle: assert property (p_idle) else $error("ready while idle");
    property p_err_rdy; pslverr_o |-> pready_o; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    property p_err_data; pslverr_o && !pwrite_i |-> prdata_o == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("error read not zero");
    property p_nopin; cc_oe_o[31:28] == 4'h0; endproperty
    a_nopin: assert property (p_nopin) else $error("pinless channel drives");
    property p_rst; $fell(sys_rst_i) |-> !irq_o && cc_oe_o == 32'h0 && cc_out_o == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    cover property (pslverr_o);
    cover property (irq_o);
    cover property ($rose(cc_out_o[0]));
endmodule

// file: tb/dacc_pins.sv
// port pin model: pin level seen by the block
// assumes the bench drives pins that the block leaves undriven
`timescale 1ns/1ps
module dacc_pins (
    input  wire logic [31:0] drv_i,
    input  wire logic [31:0] out_i,
    input  wire logic [31:0] oe_i,
    output wire logic [31:0] level_o
);
    // block wins where it drives, outside signal elsewhere
    assign level_o = (oe_i & out_i) | (~oe_i & drv_i);
endmodule

// file: tb/dacc_top_tb.sv
// self-checking bench for the dual array capture/compare block
// assumes dacc_top, dacc_pins and dacc_checker compiled before it
`timescale 1ns/1ps
module dacc_top_tb;
    logic        mclk_i, sys_rst_i, psel_i, penable_i, pwrite_i, gp_ovf_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, drv;
    logic [1:0]  ext_cnt_i;
    wire  [31:0] prdata_o, cc_in_i, cc_out_o, cc_oe_o;
    wire         pready_o, pslverr_o, irq_o;
    int          n_mismatch, check_count;
    dacc_top dut (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .cc_in_i, .cc_out_o, .cc_oe_o, .ext_cnt_i,
        .gp_ovf_i, .irq_o);
    dacc_pins pins (.drv_i(drv), .out_i(cc_out_o), .oe_i(cc_oe_o), .level_o(cc_in_i));
    task automatic chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input bit w, input [11:0] a, input [31:0] d,
                       output [31:0] q, output e);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        // look between edges so the answer is read as the next rising edge will see it
        do begin @(negedge mclk_i); n++; end while (pready_o !== 1'b1 && n < 50);
        q = prdata_o;
        e = pslverr_o;
        @(posedge mclk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        logic [31:0] q;
        logic        e;
        bus(1'b1, a, d, q, e);
    endtask
    task automatic rd(input [11:0] a, input [31:0] exp, input logic err);
        logic [31:0] q;
        logic        e;
        bus(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask
    task automatic pulse(input int n, input bit ext);
        repeat (n) begin
            @(posedge mclk_i) if (ext) ext_cnt_i <= 2'h2; else gp_ovf_i <= 1'b1;
            @(posedge mclk_i) if (ext) ext_cnt_i <= 2'h0; else gp_ovf_i <= 1'b0;
        end
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic t_map();
        rd(12'h130, 32'h0, 1'b1);
        rd(12'h100, 32'h0, 1'b0);
    endtask
    task automatic t_reload();
        wr(12'h110, 32'h00001234);
        wr(12'h100, 32'h0000fffe);
        wr(12'h120, 32'h000f000d);
        pulse(2, 1'b0);
        rd(12'h100, 32'h00001234, 1'b0);
        pulse(3, 1'b1);
        rd(12'h108, 32'h00000003, 1'b0);
    endtask
    task automatic t_cap();
        wr(12'h108, 32'h00000055);
        wr(12'h0c0, 32'h00000022);
        @(posedge mclk_i) drv <= 32'h00010000;
        rd(12'h040, 32'h0, 1'b0);
        drv <= 32'h0;
        rd(12'h040, 32'h00000055, 1'b0);
        rd(12'h128, 32'h00010000, 1'b0);
        wr(12'h128, 32'h00010000);
        rd(12'h128, 32'h0, 1'b0);
    endtask
    task automatic t_tog();
        wr(12'h000, 32'h00001236);
        wr(12'h080, 32'h00000006);
        pulse(2, 1'b0);
        chk({30'h0, cc_oe_o[0], cc_out_o[0]}, 32'h3);
        chk({31'h0, irq_o}, 32'h0);
        wr(12'h12c, 32'h00000001);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, irq_o}, 32'h1);
        wr(12'h128, 32'h00000001);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, irq_o}, 32'h0);
    endtask
    task automatic t_m3();
        wr(12'h004, 32'h00001237);
        wr(12'h084, 32'h0000000a);
        pulse(1, 1'b0);
        chk({30'h0, cc_oe_o[1], cc_out_o[1]}, 32'h3);
        wr(12'h100, 32'h0000ffff);
        pulse(1, 1'b0);
        chk({30'h0, cc_oe_o[1], cc_out_o[1]}, 32'h2);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        {sys_rst_i, psel_i, penable_i, pwrite_i, gp_ovf_i} = 5'h10;
        {paddr_i, pwdata_i, drv, ext_cnt_i} = '0;
        repeat (8) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_map();
        t_reload();
        t_cap();
        t_tog();
        t_m3();
        report_and_stop();
    end
endmodule
bind dacc_top dacc_checker u_chk (.*);
